// File: include/arh_regs.svh
// constants for the receive-list host controller: offsets, field positions, reset values
`ifndef ARH_REGS_SVH
`define ARH_REGS_SVH

// ------------------------------------------------------------
// software register offsets (byte addresses)
// ------------------------------------------------------------
`define ARH_OFS_CTRL      8'h00
`define ARH_OFS_BUF_BASE  8'h04
`define ARH_OFS_BUF_SIZE  8'h08
`define ARH_OFS_AREA0     8'h0c
`define ARH_OFS_AREA1     8'h10
`define ARH_OFS_STATUS    8'h14
`define ARH_OFS_POLL      8'h18

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define ARH_CTRL_CTX      0
`define ARH_CTRL_IRQ      1
`define ARH_CTRL_BUILD    4
`define ARH_CTRL_POLL     5
`define ARH_CTRL_SLOT_LO  8
`define ARH_CTRL_SLOT_HI  11

// ------------------------------------------------------------
// status register fields
// ------------------------------------------------------------
`define ARH_ST_BUSY       0
`define ARH_ST_ERR_ALIGN  1
`define ARH_ST_ERR_BUSY   2
`define ARH_ST_LIST0      4
`define ARH_ST_LIST1      5
`define ARH_ST_NEXT0_LO   8
`define ARH_ST_NEXT1_LO   12

// ------------------------------------------------------------
// device register offsets, one pair per context
// ------------------------------------------------------------
`define ARH_DEV_PTR0      8'h0c
`define ARH_DEV_CTLSET0   8'h00
`define ARH_DEV_PTR1      8'h2c
`define ARH_DEV_CTLSET1   8'h20
`define ARH_DEV_RUN_BIT   15
`define ARH_DEV_WAKE_BIT  12

// ------------------------------------------------------------
// descriptor layout and constant field values
// ------------------------------------------------------------
`define ARH_DESC_CMD      4'h2
`define ARH_DESC_KEY      3'b000
`define ARH_DESC_S        1'b1
`define ARH_DESC_I_ON     2'b11
`define ARH_DESC_I_OFF    2'b00
`define ARH_DESC_B        2'b11
`define ARH_DESC_Z_MORE   4'h1
`define ARH_DESC_Z_LAST   4'h0
`define ARH_Q_BRANCH      2'd2
`define ARH_Q_STATUS      2'd3
`define ARH_SLOT_BITS     4

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define ARH_RST_WORD      32'h0000_0000

`endif

// File: include/arh_pkg.sv
// types for the receive-list host controller
package arh_pkg;
    // sequencer states, gray coded along build path
    typedef enum logic [2:0]
    {
        ARH_IDLE  = 3'b000,
        ARH_WDESC = 3'b001,
        ARH_LINK  = 3'b011,
        ARH_KICK  = 3'b010,
        ARH_POLL  = 3'b110,
        ARH_PWAIT = 3'b111
    } arh_state_t;
endpackage

// File: src/arh_desc_word.sv
// composer for one quadlet of a receive buffer descriptor
`timescale 1ns/1ps
`include "arh_regs.svh"

module arh_desc_word
(
    // selection
    input  wire logic [1:0]  i_quad,
    // descriptor fields
    input  wire logic        i_irq_en,
    input  wire logic [15:0] i_size,
    input  wire logic [31:0] i_base,
    // composed quadlet
    output logic      [31:0] o_word
);
    // header quadlet pieces
    wire logic [1:0]  irq_code;   // interrupt selection
    wire logic [31:0] head_word;  // quadlet 0

    assign irq_code  = i_irq_en ? `ARH_DESC_I_ON : `ARH_DESC_I_OFF;
    assign head_word = {`ARH_DESC_CMD, `ARH_DESC_S, `ARH_DESC_KEY, 2'b00, irq_code,
                        `ARH_DESC_B, 2'b00, i_size};

    // quadlet select: new descriptor is always last, so branch zero, Z zero
    always_comb
    begin
        case (i_quad)
            2'd0:    o_word = head_word;
            2'd1:    o_word = {i_base[31:2], 2'b00};
            2'd2:    o_word = {28'h000_0000, `ARH_DESC_Z_LAST};
            default: o_word = {16'h0000, i_size};  // residual starts at full size, status zero
        endcase
    end
endmodule

// File: src/arh_host.sv
// host side controller that builds receive descriptor lists and starts the two contexts
`timescale 1ns/1ps
`include "arh_regs.svh"

module arh_host
(
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst_b,
    // software register port
    input  wire logic [7:0]  i_sw_addr,
    input  wire logic [31:0] i_sw_wdata,
    input  wire logic        i_sw_wr,
    input  wire logic        i_sw_rd,
    output logic      [31:0] o_sw_rdata,
    // device register port
    output logic      [7:0]  o_dev_addr,
    output logic      [31:0] o_dev_wdata,
    output logic             o_dev_wr,
    // host memory port, quadlet wide
    output logic      [31:0] o_mem_addr,
    output logic      [31:0] o_mem_wdata,
    output logic             o_mem_wr,
    output logic             o_mem_rd,
    input  wire logic [31:0] i_mem_rdata,
    // status
    output logic             o_busy
);
    // ------------------------------------------------------------
    // reset release through two flops
    // ------------------------------------------------------------
    logic rst_meta_reg;  // first stage, read only by second
    logic rst_sync_reg;  // released reset, active high when running

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    wire logic rst_b;  // synchronised active low reset
    assign rst_b = rst_sync_reg;

    // ------------------------------------------------------------
    // address arithmetic shared by descriptor and patch writes
    // ------------------------------------------------------------
    function automatic logic [31:0] slot_addr(input logic [31:0] area, input logic [3:0] slot,
                                              input logic [1:0] quad);
        slot_addr = {area[31:8] + 24'h00_0000, slot, quad, 2'b00};  // sixteen byte slots
    endfunction

    // ------------------------------------------------------------
    // software visible state
    // ------------------------------------------------------------
    logic [31:0] buf_base_reg;     // buffer base for next build
    logic [15:0] buf_size_reg;     // buffer size in bytes for next build
    logic [31:0] area_reg [0:1];   // descriptor area per context
    logic        ctx_reg;          // context of current order
    logic        irq_reg;          // completion interrupt wanted
    logic [3:0]  poll_slot_reg;    // slot to poll
    logic        list_reg [0:1];   // context already holds a program
    logic [3:0]  next_reg [0:1];   // next free slot per context
    logic        err_align_reg;    // sticky: misaligned buffer refused
    logic        err_busy_reg;     // sticky: order while busy refused
    logic [31:0] poll_reg;         // last status quadlet read back
    logic [31:0] rdata_reg;        // read data, one cycle after strobe

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    arh_pkg::arh_state_t state_reg;
    arh_pkg::arh_state_t state_next;
    logic [1:0]          quad_reg;  // quadlet counter during descriptor write

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire logic        wr_ctrl;     // write to control
    wire logic        wr_status;   // write-one-to-clear of errors
    wire logic        idle;        // sequencer free
    wire logic        ord_build;   // build order presented
    wire logic        ord_poll;    // poll order presented
    wire logic        misaligned;  // buffer size or base not whole quadlets
    wire logic        go_build;    // build accepted
    wire logic        go_poll;     // poll accepted
    wire logic        bad_align;   // build refused for alignment
    wire logic        bad_busy;    // order refused while busy
    wire logic [31:0] status_word; // assembled status

    assign wr_ctrl    = i_sw_wr && (i_sw_addr == `ARH_OFS_CTRL);
    assign wr_status  = i_sw_wr && (i_sw_addr == `ARH_OFS_STATUS);
    assign idle       = (state_reg == arh_pkg::ARH_IDLE);
    assign ord_build  = wr_ctrl && i_sw_wdata[`ARH_CTRL_BUILD];
    assign ord_poll   = wr_ctrl && i_sw_wdata[`ARH_CTRL_POLL] && !i_sw_wdata[`ARH_CTRL_BUILD];
    assign misaligned = (buf_size_reg[1:0] != 2'b00) || (buf_base_reg[1:0] != 2'b00);
    assign go_build   = ord_build && idle && !misaligned;
    assign go_poll    = ord_poll && idle;
    assign bad_align  = ord_build && idle && misaligned;
    assign bad_busy   = (ord_build || ord_poll) && !idle;
    assign o_busy     = !idle;

    assign status_word = {16'h0000, next_reg[1], next_reg[0], 2'b00, list_reg[1], list_reg[0],
                          1'b0, err_busy_reg, err_align_reg, !idle};

    // ------------------------------------------------------------
    // read mux, unmapped addresses read zero
    // ------------------------------------------------------------
    wire logic [31:0] rd_mux;
    assign rd_mux = (i_sw_addr == `ARH_OFS_CTRL)     ? {20'h0_0000, poll_slot_reg, 6'h00, irq_reg, ctx_reg} :
                    (i_sw_addr == `ARH_OFS_BUF_BASE) ? buf_base_reg :
                    (i_sw_addr == `ARH_OFS_BUF_SIZE) ? {16'h0000, buf_size_reg} :
                    (i_sw_addr == `ARH_OFS_AREA0)    ? area_reg[0] :
                    (i_sw_addr == `ARH_OFS_AREA1)    ? area_reg[1] :
                    (i_sw_addr == `ARH_OFS_STATUS)   ? status_word :
                    (i_sw_addr == `ARH_OFS_POLL)     ? poll_reg : `ARH_RST_WORD;

    // read data stand only in the cycle after the strobe
    always_ff @(posedge i_mclk or negedge rst_b)
    begin
        if (!rst_b)
            rdata_reg <= `ARH_RST_WORD;
        else
            rdata_reg <= i_sw_rd ? rd_mux : `ARH_RST_WORD;
    end
    assign o_sw_rdata = rdata_reg;

    // ------------------------------------------------------------
    // configuration registers, frozen while the sequencer works
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            buf_base_reg  <= `ARH_RST_WORD;
            buf_size_reg  <= 16'h0000;
            area_reg[0]   <= `ARH_RST_WORD;
            area_reg[1]   <= `ARH_RST_WORD;
            ctx_reg       <= 1'b0;
            irq_reg       <= 1'b0;
            poll_slot_reg <= 4'h0;
        end
        else if (idle && i_sw_wr)
        begin
            // area bases keep 256 byte alignment
            case (i_sw_addr)
                `ARH_OFS_BUF_BASE: buf_base_reg <= i_sw_wdata;
                `ARH_OFS_BUF_SIZE: buf_size_reg <= i_sw_wdata[15:0];
                `ARH_OFS_AREA0:    area_reg[0]  <= {i_sw_wdata[31:8], 8'h00};
                `ARH_OFS_AREA1:    area_reg[1]  <= {i_sw_wdata[31:8], 8'h00};
                `ARH_OFS_CTRL:
                begin
                    ctx_reg       <= i_sw_wdata[`ARH_CTRL_CTX];
                    irq_reg       <= i_sw_wdata[`ARH_CTRL_IRQ];
                    poll_slot_reg <= i_sw_wdata[`ARH_CTRL_SLOT_HI:`ARH_CTRL_SLOT_LO];
                end
                default: ;  // other offsets hold nothing writable
            endcase
        end
    end

    // ------------------------------------------------------------
    // sticky error flags, a new error wins over a clear
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            err_align_reg <= 1'b0;
            err_busy_reg  <= 1'b0;
        end
        else
        begin
            err_align_reg <= bad_align || (err_align_reg && !(wr_status && i_sw_wdata[`ARH_ST_ERR_ALIGN]));
            err_busy_reg  <= bad_busy || (err_busy_reg && !(wr_status && i_sw_wdata[`ARH_ST_ERR_BUSY]));
        end
    end

    // ------------------------------------------------------------
    // descriptor quadlet composer
    // ------------------------------------------------------------
    wire logic [31:0] desc_word;  // quadlet quad_reg of new descriptor
    arh_desc_word u_word
    (
        .i_quad   (quad_reg),
        .i_irq_en (irq_reg),
        .i_size   (buf_size_reg),
        .i_base   (buf_base_reg),
        .o_word   (desc_word)
    );

    // per-context addresses of the new and the previous descriptor
    wire logic [3:0]  cur_slot;   // slot being built
    wire logic [3:0]  prev_slot;  // last descriptor of the program
    wire logic [31:0] new_addr;   // start of new descriptor
    wire logic [31:0] kick_word;  // run for a fresh program, wake after append
    wire logic [7:0]  ptr_ofs;    // device pointer register of context
    wire logic [7:0]  ctl_ofs;    // device control set register of context

    assign cur_slot  = next_reg[ctx_reg];
    assign prev_slot = cur_slot - 4'h1;
    assign new_addr  = slot_addr(area_reg[ctx_reg], cur_slot, 2'd0);
    assign ptr_ofs   = ctx_reg ? `ARH_DEV_PTR1 : `ARH_DEV_PTR0;
    assign ctl_ofs   = ctx_reg ? `ARH_DEV_CTLSET1 : `ARH_DEV_CTLSET0;
    assign kick_word = list_reg[ctx_reg] ? (32'h1 << `ARH_DEV_WAKE_BIT)   // stalled context re-reads
                                         : (32'h1 << `ARH_DEV_RUN_BIT);   // start at pointer

    // ------------------------------------------------------------
    // sequencer: build walks wdesc, link, kick; poll walks poll, pwait
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            arh_pkg::ARH_IDLE:
                if (go_build)
                    state_next = arh_pkg::ARH_WDESC;
                else if (go_poll)
                    state_next = arh_pkg::ARH_POLL;
            arh_pkg::ARH_WDESC:
                if (quad_reg == 2'd3)
                    state_next = arh_pkg::ARH_LINK;
            arh_pkg::ARH_LINK:  state_next = arh_pkg::ARH_KICK;
            arh_pkg::ARH_KICK:  state_next = arh_pkg::ARH_IDLE;
            arh_pkg::ARH_POLL:  state_next = arh_pkg::ARH_PWAIT;
            arh_pkg::ARH_PWAIT: state_next = arh_pkg::ARH_IDLE;
            default:            state_next = arh_pkg::ARH_IDLE;
        endcase
    end

    // state and quadlet counter
    always_ff @(posedge i_mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= arh_pkg::ARH_IDLE;
            quad_reg  <= 2'd0;
        end
        else
        begin
            state_reg <= state_next;
            quad_reg  <= (state_reg == arh_pkg::ARH_WDESC) ? quad_reg + 2'd1 : 2'd0;
        end
    end

    // ------------------------------------------------------------
    // program bookkeeping per context
    // ------------------------------------------------------------
    // the whole descriptor lands before it is linked, so the device never sees half of it
    always_ff @(posedge i_mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            list_reg[0] <= 1'b0;
            list_reg[1] <= 1'b0;
            next_reg[0] <= 4'h0;
            next_reg[1] <= 4'h0;
        end
        else if (state_reg == arh_pkg::ARH_KICK)
        begin
            list_reg[ctx_reg] <= 1'b1;
            next_reg[ctx_reg] <= cur_slot + 4'h1;  // ring wraps; software must recycle completed slots
        end
    end

    // ------------------------------------------------------------
    // memory and device strobes, all from flops
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            o_mem_addr  <= `ARH_RST_WORD;
            o_mem_wdata <= `ARH_RST_WORD;
            o_mem_wr    <= 1'b0;
            o_mem_rd    <= 1'b0;
            o_dev_addr  <= 8'h00;
            o_dev_wdata <= `ARH_RST_WORD;
            o_dev_wr    <= 1'b0;
        end
        else
        begin
            o_mem_wr <= 1'b0;
            o_mem_rd <= 1'b0;
            o_dev_wr <= 1'b0;
            case (state_reg)
                arh_pkg::ARH_WDESC:
                begin
                    // new descriptor is written as the end of the program
                    o_mem_addr  <= slot_addr(area_reg[ctx_reg], cur_slot, quad_reg);
                    o_mem_wdata <= desc_word;
                    o_mem_wr    <= 1'b1;
                end
                arh_pkg::ARH_LINK:
                    if (list_reg[ctx_reg])
                    begin
                        // touch only pointer and block count of the old last one
                        o_mem_addr  <= slot_addr(area_reg[ctx_reg], prev_slot, `ARH_Q_BRANCH);
                        o_mem_wdata <= {new_addr[31:4], `ARH_DESC_Z_MORE};
                        o_mem_wr    <= 1'b1;
                    end
                    else
                    begin
                        // empty context: program pointer names the first descriptor
                        o_dev_addr  <= ptr_ofs;
                        o_dev_wdata <= {new_addr[31:4], 3'b000, 1'b1};
                        o_dev_wr    <= 1'b1;
                    end
                arh_pkg::ARH_KICK:
                begin
                    o_dev_addr  <= ctl_ofs;
                    o_dev_wdata <= kick_word;
                    o_dev_wr    <= 1'b1;
                end
                arh_pkg::ARH_POLL:
                begin
                    // residual and status share one quadlet, so one read sees a consistent pair
                    o_mem_addr <= slot_addr(area_reg[ctx_reg], poll_slot_reg, `ARH_Q_STATUS);
                    o_mem_rd   <= 1'b1;
                end
                default: ;  // idle and wait states drive no strobe
            endcase
        end
    end

    // ------------------------------------------------------------
    // poll result capture
    // ------------------------------------------------------------
    // upper half is the device's copy of its control status, lower half bytes left
    always_ff @(posedge i_mclk or negedge rst_b)
    begin
        if (!rst_b)
            poll_reg <= `ARH_RST_WORD;
        else if (state_reg == arh_pkg::ARH_PWAIT)
            poll_reg <= i_mem_rdata;
    end
endmodule

// File: verification/arh_host_props.sv
// checker for descriptor, pointer and kick traffic of arh_host
`timescale 1ns/1ps
module arh_host_props
(
    // clock and reset
    input wire logic        i_mclk,
    input wire logic        i_rst_b,
    // software port
    input wire logic [7:0]  i_sw_addr,
    input wire logic [31:0] i_sw_wdata,
    input wire logic        i_sw_wr,
    input wire logic        i_sw_rd,
    input wire logic [31:0] o_sw_rdata,
    // device and memory ports
    input wire logic [7:0]  o_dev_addr,
    input wire logic [31:0] o_dev_wdata,
    input wire logic        o_dev_wr,
    input wire logic [31:0] o_mem_addr,
    input wire logic [31:0] o_mem_wdata,
    input wire logic        o_mem_wr,
    input wire logic        o_mem_rd,
    input wire logic [31:0] i_mem_rdata,
    input wire logic        o_busy
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    // quadlet write strobes by position inside a descriptor
    wire q0w = o_mem_wr && (o_mem_addr[3:0] == 4'h0);
    wire q1w = o_mem_wr && (o_mem_addr[3:0] == 4'h4);
    wire q2w = o_mem_wr && (o_mem_addr[3:0] == 4'h8);
    wire q3w = o_mem_wr && (o_mem_addr[3:0] == 4'hc);
    // ------------------------------------------------------------
    // named steps of a descriptor build
    // ------------------------------------------------------------
    sequence s_tail;
        (o_mem_wr && o_mem_addr == $past(o_mem_addr) + 32'h4) [*3];
    endsequence
    sequence s_wake;
        o_dev_wr && o_dev_addr[3:0] == 4'h0 && o_dev_wdata[12];
    endsequence
    sequence s_run;
        o_dev_wr && o_dev_addr[3:0] == 4'h0 && o_dev_wdata[15];
    endsequence
    AST_CMD: assert property (q0w |-> o_mem_wdata[31:28] == 4'h2)
        else $error("command nibble wrong");
    AST_FLAGS: assert property (q0w |-> o_mem_wdata[27:24] == 4'h8)
        else $error("status or key bits wrong");
    AST_IRQ: assert property (q0w |-> o_mem_wdata[21:20] inside {2'b00, 2'b11})
        else $error("interrupt field illegal");
    AST_BRANCH: assert property (q0w |-> o_mem_wdata[19:18] == 2'b11)
        else $error("branch field wrong");
    AST_SIZE: assert property (q0w |-> o_mem_wdata[1:0] == 2'b00)
        else $error("size not quadlets");
    AST_BASE: assert property (q1w |-> o_mem_wdata[1:0] == 2'b00)
        else $error("base not aligned");
    AST_RES: assert property (q3w |-> o_mem_wdata == ($past(o_mem_wdata, 3) & 32'h0000_ffff))
        else $error("residual word wrong");
    AST_QUADS: assert property (q0w |=> s_tail)
        else $error("descriptor not four quadlets");
    AST_PTR: assert property (o_dev_wr && o_dev_addr[3:0] == 4'hc |-> o_dev_wdata[3:0] == 4'h1 ##1 s_run)
        else $error("pointer or run wrong");
    AST_LINK: assert property (q2w && o_mem_wdata != 32'h0 |-> o_mem_wdata[3:0] == 4'h1 ##1 s_wake)
        else $error("link patch or wake wrong");
endmodule
bind arh_host arh_host_props u_props (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_sw_addr(i_sw_addr),
    .i_sw_wdata(i_sw_wdata), .i_sw_wr(i_sw_wr), .i_sw_rd(i_sw_rd), .o_sw_rdata(o_sw_rdata),
    .o_dev_addr(o_dev_addr), .o_dev_wdata(o_dev_wdata), .o_dev_wr(o_dev_wr), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .o_mem_wr(o_mem_wr), .o_mem_rd(o_mem_rd), .i_mem_rdata(i_mem_rdata),
    .o_busy(o_busy));

// File: verification/arh_dev_model.sv
// host memory and two receive contexts' register model
`timescale 1ns/1ps
module arh_dev_model
(
    // clock
    input  wire logic        i_mclk,
    // memory port
    input  wire logic [31:0] i_mem_addr,
    input  wire logic [31:0] i_mem_wdata,
    input  wire logic        i_mem_wr,
    input  wire logic        i_mem_rd,
    output logic      [31:0] o_mem_rdata,
    // device register port
    input  wire logic [7:0]  i_dev_addr,
    input  wire logic [31:0] i_dev_wdata,
    input  wire logic        i_dev_wr
);
    logic [31:0] mem [0:1023];  // host memory, quadlet indexed
    logic [31:0] ptr [2];       // program pointer per context
    logic [31:0] start [2];     // first descriptor taken on run
    logic [1:0]  run = 2'b00;   // context running
    logic [1:0]  wake = 2'b00;  // wake seen
    logic [31:0] last = 32'h0;  // last word read; idle bus shows its inverse
    wire         ctx = i_dev_addr[5];  // request or response context
    // ------------------------------------------------------------
    // memory answers in the read cycle, where the host samples it
    // ------------------------------------------------------------
    assign o_mem_rdata = i_mem_rd ? mem[i_mem_addr[11:2]] : ~last;
    always @(posedge i_mclk)
    begin
        if (i_mem_wr) mem[i_mem_addr[11:2]] <= i_mem_wdata;
        if (i_mem_rd) last <= mem[i_mem_addr[11:2]];
        if (i_dev_wr && i_dev_addr[3:0] == 4'hc) ptr[ctx] <= i_dev_wdata;
        if (i_dev_wr && i_dev_addr[3:0] == 4'h0 && i_dev_wdata[15] && ptr[ctx][0])
        begin
            run[ctx] <= 1'b1;
            start[ctx] <= {ptr[ctx][31:4], 4'h0};
        end
        if (i_dev_wr && i_dev_addr[3:0] == 4'h0 && i_dev_wdata[12]) wake[ctx] <= 1'b1;
    end
endmodule

// File: verification/arh_host_tb.sv
// self-checking bench for arh_host with memory and context model
`timescale 1ns/1ps
module arh_host_tb;
    typedef struct {logic ctx; logic irq; logic app; logic [31:0] da; logic [31:0] base; logic [15:0] size;} arh_row_t;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  sa = 8'h00;
    logic [31:0] swd = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] srd, dwd, ma, mwd, mrd, d, q0;
    logic [7:0]  dad;
    logic        dwr, mwr, mrdq, busy;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    arh_row_t    r;
    // build rows: order, descriptor address expected, fields
    arh_row_t rows [3] = '{'{1'b0, 1'b1, 1'b0, 32'h100, 32'h1000, 16'h0040},
                          '{1'b1, 1'b0, 1'b0, 32'h200, 32'h2004, 16'h0100},
                          '{1'b0, 1'b1, 1'b1, 32'h110, 32'h3008, 16'h0ffc}};
    arh_host dut (.i_mclk(clk), .i_rst_b(rst_b), .i_sw_addr(sa), .i_sw_wdata(swd), .i_sw_wr(wr),
        .i_sw_rd(rd), .o_sw_rdata(srd), .o_dev_addr(dad), .o_dev_wdata(dwd), .o_dev_wr(dwr),
        .o_mem_addr(ma), .o_mem_wdata(mwd), .o_mem_wr(mwr), .o_mem_rd(mrdq), .i_mem_rdata(mrd), .o_busy(busy));
    arh_dev_model u_mem (.i_mclk(clk), .i_mem_addr(ma), .i_mem_wdata(mwd), .i_mem_wr(mwr), .i_mem_rd(mrdq),
        .o_mem_rdata(mrd), .i_dev_addr(dad), .i_dev_wdata(dwd), .i_dev_wr(dwr));
    initial forever #25 clk = ~clk;
    // ------------------------------------------------------------
    // bus tasks and compare
    // ------------------------------------------------------------
    task sw_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        sa <= a;
        swd <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task sw_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        sa <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = srd;  // data stands only in this cycle
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
            n_fail++;
        end
    endtask
    task wait_idle();
        repeat (40)
        begin
            @(posedge clk);
            #1;
            if (busy === 1'b0) break;
        end
        if (busy !== 1'b0) n_fail++;
        repeat (2) @(posedge clk);  // model takes the last strobes
    endtask
    task finish_test();
        $display("checks=%0d failures=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // hang guard, the whole run needs about a hundred cycles
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_fail++;
            finish_test();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        sw_rd(8'h14, d);
        chk(d, 32'h0);
        chk({31'h0, u_mem.run[0]}, 32'h0);
        sw_wr(8'h0c, 32'h0000_0100);
        sw_wr(8'h10, 32'h0000_02ff);  // low byte forced to zero
        for (int k = 0; k < 3; k++)
        begin
            r = rows[k];
            sw_wr(8'h04, r.base);
            sw_wr(8'h08, {16'h0, r.size});
            sw_wr(8'h00, {27'h0, 1'b1, 2'b00, r.irq, r.ctx});
            wait_idle();
            q0 = {4'h2, 1'b1, 3'b000, 2'b00, {2{r.irq}}, 2'b11, 2'b00, r.size};
            chk(u_mem.mem[r.da[11:2]], q0);
            chk(u_mem.mem[r.da[11:2] + 1], r.base & 32'hffff_fffc);
            chk(u_mem.mem[r.da[11:2] + 2], 32'h0);
            chk(u_mem.mem[r.da[11:2] + 3], {16'h0, r.size});
            if (r.app)
                chk(u_mem.mem[r.da[11:2] - 2], {r.da[31:4], 4'h1});
            else
                chk(u_mem.start[r.ctx], r.da);
        end
        chk({31'h0, u_mem.wake[0]}, 32'h1);
        // misaligned size refused
        sw_wr(8'h08, 32'h0000_0042);
        sw_wr(8'h00, 32'h0000_0011);
        wait_idle();
        sw_rd(8'h14, d);
        chk(d & 32'h7, 32'h2);
        // poll residual word of ctx0 slot0
        sw_wr(8'h00, 32'h0000_0020);
        wait_idle();
        sw_rd(8'h18, d);
        chk(d, 32'h0000_0040);
        // back-to-back build while busy, appends to ctx1
        sw_wr(8'h14, 32'h0000_0006);
        sw_wr(8'h08, 32'h0000_0080);
        sw_wr(8'h00, 32'h0000_0011);
        sw_wr(8'h00, 32'h0000_0011);
        wait_idle();
        sw_rd(8'h14, d);
        chk(d & 32'h7, 32'h4);
        chk(u_mem.mem[32'h208 >> 2], 32'h0000_0211);
        chk({31'h0, u_mem.wake[1]}, 32'h1);
        sw_rd(8'h1c, d);
        chk(d, 32'h0);
        finish_test();
    end
endmodule
